/* include/switch_config_pkg.sv */
`default_nettype none
package switch_config_pkg;
   // ----------------------------------------
   // capture and decode constants
   // ----------------------------------------
   localparam logic [3:0] RATE_625K      = 4'h7;
   localparam logic [3:0] RATE_ALARM_MIN = 4'h8;
   localparam logic [7:0] ADDR_MIN       = 8'h60;
   localparam logic [7:0] ADDR_MAX       = 8'h7f;
   localparam logic [7:0] ADDR_DEFAULT   = 8'h61;
   localparam int         SETTLE_CYCLES  = 4;
   localparam logic [4:0] LEN_SHORT      = 5'h11;
   localparam logic [5:0] LEN_LONG       = 6'h20;
   localparam logic [4:0] SLAVES_16BIT   = 5'h08;
   localparam logic [4:0] SLAVES_8BIT    = 5'h10;
   // positions inside the operation mode switch bank
   localparam int         MODE_BIT_WIDTH = 0;
   localparam int         MODE_BIT_LEN_A = 1;
   localparam int         MODE_BIT_LEN_B = 2;
endpackage : switch_config_pkg
`default_nettype wire

/* testbench/power_on_switch_config_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module switch_config_checker (
   // clock, reset and enable
   input wire logic       clk_sys,
   input wire logic       resetn,
   input wire logic       clk_en,
   // switch inputs
   input wire logic [3:0] link_rate_selector,
   input wire logic [3:0] operating_mode_switch_bank,
   input wire logic [3:0] station_tens_switch,
   input wire logic [3:0] station_ones_switch,
   input wire logic       slave0_connect_param,
   // applied configuration
   input wire logic       config_valid,
   input wire logic       rate_625k_sel,
   input wire logic       rate_unusable,
   input wire logic       switch_alarm,
   input wire logic       io_8bit_mode,
   input wire logic [4:0] max_slaves,
   input wire logic [5:0] transfer_bytes,
   input wire logic       transfer_len_bad,
   input wire logic [7:0] station_addr,
   input wire logic       addr_error,
   input wire logic       fieldbus_enable,
   input wire logic       slave0_connect
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence capture_s; $rose(config_valid); endsequence
   alarm_rate_a: assert property (capture_s |->
      switch_alarm == ($past(link_rate_selector) >= 4'h8)) else $error("alarm");
   rate_sel_a: assert property (capture_s |->
      rate_625k_sel == ($past(link_rate_selector) == 4'h7)) else $error("rate");
   mode_width_a: assert property (capture_s |->
      max_slaves == ($past(operating_mode_switch_bank[0]) ? 5'h10 : 5'h08)) else $error("width");
   len_sel_a: assert property (capture_s |-> transfer_bytes ==
      ($past(operating_mode_switch_bank[2:1]) == 2'b10 ? 6'h20 : 6'h11)) else $error("bytes");
   addr_form_a: assert property (capture_s |->
      station_addr == {$past(station_tens_switch), $past(station_ones_switch)}) else $error("a");
   addr_range_a: assert property (config_valid |->
      addr_error == (station_addr < 8'h60 || station_addr > 8'h7f)) else $error("range");
   bus_off_a: assert property (addr_error |-> !fieldbus_enable) else $error("bus");
   hold_cfg_a: assert property (config_valid |=> config_valid && $stable(station_addr)
      && $stable(switch_alarm) && $stable(transfer_bytes)) else $error("hold");
   unusable_rate_a: assert property (capture_s |->
      rate_unusable == ($past(link_rate_selector) < 4'h7)) else $error("unusable");
   mode_flag_a: assert property (capture_s |->
      io_8bit_mode == $past(operating_mode_switch_bank[0])) else $error("mode");
   len_flag_a: assert property (capture_s |->
      transfer_len_bad == $past(operating_mode_switch_bank[1])) else $error("len");
   slave_conn_a: assert property (capture_s |->
      slave0_connect == $past(slave0_connect_param)) else $error("slave0");
   bus_gate_a: assert property (config_valid |-> fieldbus_enable ==
      (!addr_error && rate_625k_sel && !transfer_len_bad)) else $error("gate");
   enable_freeze_a: assert property (!clk_en |=> $stable(config_valid)
      && $stable(station_addr) && $stable(fieldbus_enable)) else $error("freeze");
endmodule : switch_config_checker
bind power_on_switch_config switch_config_checker u_chk (.*);
`default_nettype wire

/* testbench/power_on_switch_config_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module power_on_switch_config_tb_top;
   logic clk_sys = 1'b0, resetn = 1'b0, clk_en = 1'b1, cv, r6, ru, al, m8, lb, ae, fb, s0;
   logic [4:0] ms; logic [5:0] nb; logic [7:0] sa;
   wire logic [3:0] rs, mb, ts, os; wire logic pp;
   int miscompares = 0, samples_checked = 0;
   initial forever #5 clk_sys = ~clk_sys;
   switch_panel u_panel (.clk_sys, .rate(rs), .mode(mb), .tens(ts), .ones(os), .conn(pp));
   power_on_switch_config DUT (.clk_sys, .resetn, .clk_en(clk_en), .link_rate_selector(rs),
      .operating_mode_switch_bank(mb), .station_tens_switch(ts), .station_ones_switch(os),
      .slave0_connect_param(pp), .config_valid(cv), .rate_625k_sel(r6), .rate_unusable(ru),
      .switch_alarm(al), .io_8bit_mode(m8), .max_slaves(ms), .transfer_bytes(nb),
      .transfer_len_bad(lb), .station_addr(sa), .addr_error(ae), .fieldbus_enable(fb),
      .slave0_connect(s0));
   task chk(input string n, input logic [7:0] s, e);
      samples_checked++;
      if (s !== e) begin miscompares++; $display("[FAIL] %s exp %h got %h", n, e, s); end
   endtask : chk
   task finish_test;
      $display("checks %0d miscompares %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : finish_test
   // stall: enabled-low edges right after release, which must delay the capture
   task automatic run(input logic [3:0] r, b, t, o, input logic p, input int stall);
      int n = 0;
      logic bad;
      bad = {t, o} < 8'h60 || {t, o} > 8'h7f;
      u_panel.set(r, b, t, o, p);
      resetn <= 1'b0;
      repeat (20) @(posedge clk_sys);
      resetn <= 1'b1;
      clk_en <= (stall == 0);
      while (cv !== 1'b1 && n < 40)
      begin
         @(posedge clk_sys);
         n++;
         if (n == stall)
            clk_en <= 1'b1;
         #1;
      end
      if (cv !== 1'b1)
      begin
         miscompares++;
         finish_test();
      end
      chk("cycles", n[7:0], 8'(5 + stall));
      repeat (2)
      begin
         chk("alarm", al, r >= 4'h8);
         chk("unusable", ru, r < 4'h7);
         chk("rate", r6, r == 4'h7);
         chk("width", {m8, ms}, b[0] ? 8'h30 : 8'h08);
         chk("bytes", nb, b[2:1] == 2'b10 ? 6'h20 : 6'h11);
         chk("len_bad", lb, b[1]);
         chk("addr", sa, {t, o});
         chk("bus", {ae, fb}, {bad, !bad && r == 4'h7 && !b[1]});
         chk("slave0", s0, p);
         u_panel.set(~r, ~b, ~t, ~o, ~p);
         repeat (3) @(posedge clk_sys);
         #1;
      end
   endtask : run
   initial
   begin
      run(4'h7, 4'h4, 4'h6, 4'h1, 1'b1, 0);
      run(4'h8, 4'h9, 4'h7, 4'hf, 1'b0, 3);
      run(4'h6, 4'h0, 4'h5, 4'hf, 1'b0, 0);
      run(4'hf, 4'hc, 4'h8, 4'h0, 1'b1, 0);
      run(4'h7, 4'h2, 4'h7, 4'h0, 1'b1, 2);
      finish_test();
   end
endmodule : power_on_switch_config_tb_top
`default_nettype wire

/* testbench/switch_panel.sv */
`timescale 1ns/1ps
`default_nettype none
module switch_panel (
   // clock
   input  wire logic       clk_sys,
   // switch positions, preset to the factory settings
   output var  logic [3:0] rate = 4'h7,
   output var  logic [3:0] mode = 4'h4,
   output var  logic [3:0] tens = 4'h6,
   output var  logic [3:0] ones = 4'h1,
   // stored connection parameter
   output var  logic       conn = 1'b0
);
   // slave link rate and distinct addresses are settled off-board
   task set(input logic [3:0] r, m, t, o, input logic c);
      @(posedge clk_sys);
      {rate, mode, tens, ones, conn} <= {r, m, t, o, c};
   endtask : set
endmodule : switch_panel
`default_nettype wire

/* verilog/addr_check.sv */
`timescale 1ns/1ps
`default_nettype none
module addr_check
   import switch_config_pkg::*;
(
   // digits
   input  wire logic [3:0] tens_digit,
   input  wire logic [3:0] ones_digit,
   // result
   output wire logic [7:0] station_addr,
   output wire logic       addr_legal
);
   assign station_addr = {tens_digit, ones_digit};
   assign addr_legal   = (station_addr >= ADDR_MIN) && (station_addr <= ADDR_MAX);
endmodule : addr_check
`default_nettype wire

/* verilog/power_on_switch_config.sv */
`timescale 1ns/1ps
`default_nettype none
module power_on_switch_config
   import switch_config_pkg::*;
(
   // clock, reset and enable
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   input  wire logic       clk_en,
   // front-panel switches and stored parameter
   input  wire logic [3:0] link_rate_selector,
   input  wire logic [3:0] operating_mode_switch_bank,
   input  wire logic [3:0] station_tens_switch,
   input  wire logic [3:0] station_ones_switch,
   input  wire logic       slave0_connect_param,
   // applied configuration
   output logic            config_valid,
   output logic            rate_625k_sel,
   output logic            rate_unusable,
   output logic            switch_alarm,
   output logic            io_8bit_mode,
   output logic [4:0]      max_slaves,
   output logic [5:0]      transfer_bytes,
   output logic            transfer_len_bad,
   output logic [7:0]      station_addr,
   output logic            addr_error,
   output logic            fieldbus_enable,
   output logic            slave0_connect
);
   // ----------------------------------------
   // capture sequencing
   // ----------------------------------------
   // a short settle delay lets switch inputs stabilise after power-up
   typedef enum logic [1:0] {ST_SETTLE, ST_CAPTURE, ST_HOLD} cap_state_e;
   cap_state_e state_reg;
   cap_state_e state_next;
   logic [2:0] settle_reg;
   wire        settle_done = (settle_reg == 3'(SETTLE_CYCLES - 1));
   wire        capture     = (state_reg == ST_CAPTURE);

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_SETTLE:  if (settle_done) state_next = ST_CAPTURE;
         ST_CAPTURE: state_next = ST_HOLD;
         ST_HOLD:    state_next = ST_HOLD;
         // the fourth code is unused; recover via ST_SETTLE, with no new settle delay as settle_reg stays at its end count
         default:    state_next = ST_SETTLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg  <= ST_SETTLE;
         settle_reg <= 3'h0;
      end
      else if (clk_en)
      begin
         state_reg <= state_next;
         if (!settle_done)
            settle_reg <= settle_reg + 3'h1;
      end
   end

   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire [7:0] addr_w;
   wire       addr_ok_w;
   addr_check u_addr_check (
      .tens_digit   (station_tens_switch),
      .ones_digit   (station_ones_switch),
      .station_addr (addr_w),
      .addr_legal   (addr_ok_w)
   );

   wire       alarm_w    = (link_rate_selector >= RATE_ALARM_MIN);
   wire       r625_w     = (link_rate_selector == RATE_625K);
   // no alarm for 0..6: only marks the link as not runnable
   wire       unusable_w = (link_rate_selector < RATE_625K);
   // bit 3 (fourth position) deliberately unread
   wire       mode8_w    = operating_mode_switch_bank[MODE_BIT_WIDTH];
   wire [4:0] slaves_w   = mode8_w ? SLAVES_8BIT : SLAVES_16BIT;
   wire       len_a_w    = operating_mode_switch_bank[MODE_BIT_LEN_A];
   wire       len_b_w    = operating_mode_switch_bank[MODE_BIT_LEN_B];
   // position 2 on is undefined; flagged, short length used
   wire [5:0] bytes_w    = (!len_a_w && len_b_w) ? LEN_LONG : {1'b0, LEN_SHORT};
   wire       len_bad_w  = len_a_w;
   wire       run_ok_w   = addr_ok_w && r625_w && !len_bad_w;

   // ----------------------------------------
   // applied configuration, loaded once
   // ----------------------------------------
   // one load strobe for every field keeps them coherent with config_valid
   wire        load_w = clk_en && capture;

   logic       config_valid_reg;
   logic       config_valid_next;
   logic       rate_625k_reg;
   logic       rate_625k_next;
   logic       rate_unusable_reg;
   logic       rate_unusable_next;
   logic       switch_alarm_reg;
   logic       switch_alarm_next;
   logic       io_8bit_reg;
   logic       io_8bit_next;
   logic [4:0] max_slaves_reg;
   logic [4:0] max_slaves_next;
   logic [5:0] transfer_bytes_reg;
   logic [5:0] transfer_bytes_next;
   logic       len_bad_reg;
   logic       len_bad_next;
   logic [7:0] station_addr_reg;
   logic [7:0] station_addr_next;
   logic       addr_error_reg;
   logic       addr_error_next;
   logic       fieldbus_en_reg;
   logic       fieldbus_en_next;
   logic       slave0_reg;
   logic       slave0_next;

   // ----------------------------------------
   // next values: load on the strobe, else hold
   // ----------------------------------------
   assign config_valid_next   = load_w ? 1'b1       : config_valid_reg;
   assign rate_625k_next      = load_w ? r625_w     : rate_625k_reg;
   assign rate_unusable_next  = load_w ? unusable_w : rate_unusable_reg;
   assign switch_alarm_next   = load_w ? alarm_w    : switch_alarm_reg;
   assign io_8bit_next        = load_w ? mode8_w    : io_8bit_reg;
   assign max_slaves_next     = load_w ? slaves_w   : max_slaves_reg;
   assign transfer_bytes_next = load_w ? bytes_w    : transfer_bytes_reg;
   assign len_bad_next        = load_w ? len_bad_w  : len_bad_reg;
   assign station_addr_next   = load_w ? addr_w     : station_addr_reg;
   assign addr_error_next     = load_w ? !addr_ok_w : addr_error_reg;
   assign fieldbus_en_next    = load_w ? run_ok_w   : fieldbus_en_reg;
   assign slave0_next         = load_w ? slave0_connect_param : slave0_reg;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // reset values are the factory settings, except rate_625k_sel and fieldbus_enable which reset low, so outputs read sane before capture
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         config_valid_reg <= 1'b0;
         switch_alarm_reg <= 1'b0;
         addr_error_reg   <= 1'b0;
         fieldbus_en_reg  <= 1'b0;
      end
      else
      begin
         config_valid_reg <= config_valid_next;
         switch_alarm_reg <= switch_alarm_next;
         addr_error_reg   <= addr_error_next;
         fieldbus_en_reg  <= fieldbus_en_next;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rate_625k_reg     <= 1'b0;
         rate_unusable_reg <= 1'b0;
      end
      else
      begin
         rate_625k_reg     <= rate_625k_next;
         rate_unusable_reg <= rate_unusable_next;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         io_8bit_reg        <= 1'b0;
         max_slaves_reg     <= SLAVES_16BIT;
         transfer_bytes_reg <= LEN_LONG;
         len_bad_reg        <= 1'b0;
      end
      else
      begin
         io_8bit_reg        <= io_8bit_next;
         max_slaves_reg     <= max_slaves_next;
         transfer_bytes_reg <= transfer_bytes_next;
         len_bad_reg        <= len_bad_next;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         station_addr_reg <= ADDR_DEFAULT;
         slave0_reg       <= 1'b0;
      end
      else
      begin
         station_addr_reg <= station_addr_next;
         slave0_reg       <= slave0_next;
      end
   end

   // ----------------------------------------
   // outputs, each straight from its flip-flop
   // ----------------------------------------
   assign config_valid     = config_valid_reg;
   assign rate_625k_sel    = rate_625k_reg;
   assign rate_unusable    = rate_unusable_reg;
   assign switch_alarm     = switch_alarm_reg;
   assign io_8bit_mode     = io_8bit_reg;
   assign max_slaves       = max_slaves_reg;
   assign transfer_bytes   = transfer_bytes_reg;
   assign transfer_len_bad = len_bad_reg;
   assign station_addr     = station_addr_reg;
   assign addr_error       = addr_error_reg;
   assign fieldbus_enable  = fieldbus_en_reg;
   assign slave0_connect   = slave0_reg;
endmodule : power_on_switch_config
`default_nettype wire
